/* drx_params.svh */
// constants for the debug-return, interrupt-disable, divide and barrier decoder
`ifndef DRX_PARAMS_SVH
`define DRX_PARAMS_SVH
`define DRX_MAJOR_GROUP_A    6'h00
`define DRX_MINOR_GROUP_AXF  6'h3C
`define DRX_MINOR_SLL        6'h00
`define DRX_EXT_INTDIS       10'h11D
`define DRX_EXT_SDIV         10'h2AC
`define DRX_EXT_UDIV         10'h2EC
`define DRX_EXT_DEBUG_EXCEPTION_RETURN        10'h38D
`define DRX_EHB_SHAMT        5'h03
`define DRX_IE_BIT           0
`define DRX_DIV_STEPS        6'h20
`define DRX_HAZARD_CYCLES    3'h2
`define DRX_ZERO_REG         5'h00
`endif

/* drx_pkg.sv */
// types for the debug-return, interrupt-disable, divide and barrier decoder
package drx_pkg;
  typedef enum logic [1:0] {
    DRX_EXC_NONE = 2'h0,
    DRX_EXC_CPU  = 2'h1,
    DRX_EXC_RI   = 2'h2
  } drx_exc_t;
  typedef enum logic [2:0] {
    DRX_DIV_IDLE = 3'b001,
    DRX_DIV_RUN  = 3'b010,
    DRX_DIV_FIX  = 3'b100
  } drx_div_state_t;
endpackage : drx_pkg

/* drx_divider.sv */
// iterative 32-bit signed/unsigned divider, one quotient bit per cycle
`timescale 1ns/1ps
`include "drx_params.svh"
module drx_divider
  import drx_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        start_in,
  input  wire logic        signed_in,
  input  wire logic [31:0] dividend_in,
  input  wire logic [31:0] divisor_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [31:0]      quot_out,
  output logic [31:0]      rem_out
);
  drx_div_state_t state;
  logic [31:0] quot;
  logic [31:0] rem;
  logic [31:0] dvsr;
  logic [5:0]  count;
  logic        neg_q;
  logic        neg_r;
  // operand magnitudes and one restoring step
  wire         a_neg    = signed_in & dividend_in[31];
  wire         b_neg    = signed_in & divisor_in[31];
  wire [31:0]  a_mag    = a_neg ? (32'h0 - dividend_in) : dividend_in;
  wire [31:0]  b_mag    = b_neg ? (32'h0 - divisor_in) : divisor_in;
  wire [32:0]  trial    = {rem, quot[31]};
  wire [32:0]  diff     = trial - {1'b0, dvsr};
  wire         fits     = ~diff[32];
  wire [31:0]  next_rem = fits ? diff[31:0] : trial[31:0];
  // busy from issue until results leave; a new start aborts the old one
  assign busy_out = start_in | (state != DRX_DIV_IDLE);  // see RQ19
  // iteration; zero divisor just runs out its steps, no trap
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state    <= DRX_DIV_IDLE;
      quot     <= 32'h0;
      rem      <= 32'h0;
      dvsr     <= 32'h0;
      count    <= 6'h0;
      neg_q    <= 1'b0;
      neg_r    <= 1'b0;
      done_out <= 1'b0;
      quot_out <= 32'h0;
      rem_out  <= 32'h0;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in)  // see RQ20
      begin
        state <= DRX_DIV_RUN;
        quot  <= a_mag;
        rem   <= 32'h0;
        dvsr  <= b_mag;
        count <= `DRX_DIV_STEPS;
        neg_q <= a_neg ^ b_neg;  // see RQ11
        neg_r <= a_neg;
      end
      else
      begin
        unique case (state)
          DRX_DIV_IDLE: ;
          DRX_DIV_RUN:
          begin
            rem   <= next_rem;
            quot  <= {quot[30:0], fits};
            count <= count - 6'h01;
            if (count == 6'h01)
              state <= DRX_DIV_FIX;
          end
          DRX_DIV_FIX:
          begin
            quot_out <= neg_q ? (32'h0 - quot) : quot;  // see RQ11
            rem_out  <= neg_r ? (32'h0 - rem) : rem;    // see RQ11
            done_out <= 1'b1;
            state    <= DRX_DIV_IDLE;
          end
          default: state <= DRX_DIV_IDLE;
        endcase
      end
    end
  end
endmodule : drx_divider

/* drx_hazard.sv */
// execution-hazard tracker: counts down after a status change
`timescale 1ns/1ps
`include "drx_params.svh"
module drx_hazard
  import drx_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic create_in,
  output logic      pending_out
);
  logic [2:0] count;
  assign pending_out = (count != 3'h0);
  // the change lands after a delay software must not count on
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count <= 3'h0;
    else if (create_in)
      count <= `DRX_HAZARD_CYCLES;
    else if (count != 3'h0)
      count <= count - 3'h1;
  end
endmodule : drx_hazard

/* drx_decode_exec.sv */
// decode and execute of debug return, interrupt disable, divides and hazard barrier
//
// Behaviour
// RQ1: debug return clears debug and inhibit flags, restores pc and isa mode bit.
// RQ2: debug return raises only coprocessor-unusable or reserved-instruction exceptions.
// RQ3: debug return legal only in debug mode; has no delay slot.
// RQ4: decode interrupt disable from major, minor and extended opcode fields.
// RQ5: interrupt disable writes old status to register, then clears enable bit.
// RQ6: status read and enable clear are one indivisible step.
// RQ7: no coprocessor-0 access gives coprocessor-unusable, nothing changes.
// RQ8: compatibility option makes interrupt disable a reserved instruction.
// RQ9: enable change may lag; barrier, hazard jumps, exception return guarantee it.
// RQ10: decode signed divide; dividend in bits 20..16, divisor in 25..21.
// RQ11: signed divide gives truncated quotient low, remainder high.
// RQ12: divides never trap; zero divisor leaves arbitrary results.
// RQ13: result register reads stall until the divide has finished.
// RQ14: decode unsigned divide with the same register fields.
// RQ15: unsigned divide writes quotient low and remainder high.
// RQ16: barrier is shift-left-logical of register zero by three.
// RQ17: barrier stalls issue until earlier execution hazards clear, even in slots.
// RQ18: barrier gives no instruction-fetch hazard guarantee.
// RQ19: iterative one-bit-per-cycle divider with busy until results written.
// RQ20: a newer divide aborts the older; results are the newer ones.
`timescale 1ns/1ps
`include "drx_params.svh"
module drx_decode_exec
  import drx_pkg::*;
(
  input  wire logic                 CLOCK_IN,
  input  wire logic                 RESETN_IN,
  input  wire logic                 ISSUE_VALID_IN,
  input  wire logic [31:0]          INSTR_IN,
  input  wire logic                 IN_DELAY_SLOT_IN,
  input  wire logic [31:0]          SOURCE_DATA_IN,
  input  wire logic [31:0]          TARGET_DATA_IN,
  input  wire logic                 READ_RESULT_HIGH_IN,
  input  wire logic                 READ_RESULT_LOW_IN,
  input  wire logic                 HAZARD_JUMP_IN,
  input  wire logic                 EXCEPTION_RETURN_IN,
  input  wire logic                 CP0_USABLE_IN,
  input  wire logic                 COMPAT_RELEASE1_IN,
  input  wire logic                 COMPRESSED_ISA_PRESENT_IN,
  input  wire logic                 DEBUG_MODE_FLAG_IN,
  input  wire logic [31:0]          SAVED_DEBUG_PC_IN,
  input  wire logic [31:0]          STATUS_IN,
  output logic                      STALL_OUT,
  output logic                      EXC_VALID_OUT,
  output drx_pkg::drx_exc_t         EXC_CODE_OUT,
  output logic                      STATUS_WE_OUT,
  output logic [31:0]               STATUS_OUT,
  output logic                      REG_WE_OUT,
  output logic [4:0]                REG_ADDR_OUT,
  output logic [31:0]               REG_DATA_OUT,
  output logic                      DEBUG_CLEAR_OUT,
  output logic                      PC_LOAD_OUT,
  output logic [31:0]               PC_OUT,
  output logic                      ISA_MODE_BIT_OUT,
  output logic                      SQUASH_NEXT_OUT,
  output logic                      INTR_ENABLE_EFFECTIVE_OUT,
  output logic [31:0]               RESULT_HIGH_REGISTER_OUT,
  output logic [31:0]               RESULT_LOW_REGISTER_OUT
);
  // instruction fields
  wire [5:0] major_opcode     = INSTR_IN[31:26];
  wire [4:0] source_reg_field = INSTR_IN[25:21];
  wire [4:0] target_reg_field = INSTR_IN[20:16];
  wire [9:0] ext_field        = INSTR_IN[15:6];
  wire [5:0] minor_opcode     = INSTR_IN[5:0];
  wire       group_axf        = (major_opcode == `DRX_MAJOR_GROUP_A) && (minor_opcode == `DRX_MINOR_GROUP_AXF);

  // opcode decode
  wire is_intdis  = group_axf && (source_reg_field == `DRX_ZERO_REG)
                    && (ext_field == `DRX_EXT_INTDIS);                      // see RQ4
  wire is_sdiv    = group_axf && (ext_field == `DRX_EXT_SDIV);             // see RQ10
  wire is_udiv    = group_axf && (ext_field == `DRX_EXT_UDIV);             // see RQ14
  wire is_debug_exception_return   = (INSTR_IN[31:16] == 16'h0000) && group_axf
                    && (ext_field == `DRX_EXT_DEBUG_EXCEPTION_RETURN);
  wire is_barrier = (INSTR_IN[31:16] == 16'h0000) && (INSTR_IN[15:11] == `DRX_EHB_SHAMT)
                    && (INSTR_IN[10:0] == 11'h000);                         // see RQ16

  // divider and hazard helpers
  logic        div_busy;
  logic        div_done;
  logic [31:0] div_quot;
  logic [31:0] div_rem;
  logic        hazard_pending;
  logic        ie_shadow;

  // interlocks
  wire result_read  = READ_RESULT_HIGH_IN | READ_RESULT_LOW_IN;
  wire read_stall   = ISSUE_VALID_IN & result_read & (div_busy | div_done);  // see RQ13
  wire barrier_wait = ISSUE_VALID_IN & is_barrier & hazard_pending;        // see RQ17
  wire hazard_clear = (is_barrier & ISSUE_VALID_IN) | HAZARD_JUMP_IN | EXCEPTION_RETURN_IN;  // see RQ9
  assign STALL_OUT  = read_stall | barrier_wait;

  // go terms; barrier waits only on execution hazards, not fetch ones
  wire go         = ISSUE_VALID_IN & ~STALL_OUT;                           // see RQ18
  wire debug_exception_return_ri   = is_debug_exception_return & ~DEBUG_MODE_FLAG_IN;                        // see RQ3
  wire debug_exception_return_cpu  = is_debug_exception_return & DEBUG_MODE_FLAG_IN & ~CP0_USABLE_IN;        // see RQ2
  wire debug_exception_return_ok   = go & is_debug_exception_return & DEBUG_MODE_FLAG_IN & CP0_USABLE_IN;
  wire intdis_ri  = is_intdis & COMPAT_RELEASE1_IN;                        // see RQ8
  wire intdis_cpu = is_intdis & ~COMPAT_RELEASE1_IN & ~CP0_USABLE_IN;      // see RQ7
  wire intdis_ok  = go & is_intdis & ~COMPAT_RELEASE1_IN & CP0_USABLE_IN;
  wire div_start  = go & (is_sdiv | is_udiv);                              // see RQ12

  // exception selection
  wire       exc_ri    = go & (debug_exception_return_ri | intdis_ri);
  wire       exc_cpu   = go & (debug_exception_return_cpu | intdis_cpu);
  drx_exc_t  next_exc;
  assign next_exc = exc_ri ? DRX_EXC_RI : (exc_cpu ? DRX_EXC_CPU : DRX_EXC_NONE);

  // debug return target
  wire [31:0] next_pc  = COMPRESSED_ISA_PRESENT_IN ? {SAVED_DEBUG_PC_IN[31:1], 1'b0}
                         : SAVED_DEBUG_PC_IN;                              // see RQ1
  wire        next_isa = COMPRESSED_ISA_PRESENT_IN & SAVED_DEBUG_PC_IN[0];

  // status with enable cleared, from the same sampled value
  logic [31:0] next_status;
  always_comb
  begin
    next_status = STATUS_IN;
    next_status[`DRX_IE_BIT] = 1'b0;                                       // see RQ5
  end

  drx_divider u_divider (
    .clk_in      (CLOCK_IN),
    .resetn_in   (RESETN_IN),
    .start_in    (div_start),
    .signed_in   (is_sdiv),
    .dividend_in (TARGET_DATA_IN),
    .divisor_in  (SOURCE_DATA_IN),
    .busy_out    (div_busy),
    .done_out    (div_done),
    .quot_out    (div_quot),
    .rem_out     (div_rem)
  );

  drx_hazard u_hazard (
    .clk_in      (CLOCK_IN),
    .resetn_in   (RESETN_IN),
    .create_in   (intdis_ok),
    .pending_out (hazard_pending)
  );

  // register and status write-back in one cycle, so nothing slips between
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      STATUS_WE_OUT <= 1'b0;
      STATUS_OUT    <= 32'h0;
      REG_WE_OUT    <= 1'b0;
      REG_ADDR_OUT  <= 5'h00;
      REG_DATA_OUT  <= 32'h0;
    end
    else
    begin
      STATUS_WE_OUT <= intdis_ok;                                          // see RQ6
      REG_WE_OUT    <= intdis_ok & (target_reg_field != `DRX_ZERO_REG);    // see RQ5
      if (intdis_ok)
      begin
        STATUS_OUT   <= next_status;
        REG_ADDR_OUT <= target_reg_field;
        REG_DATA_OUT <= STATUS_IN;
      end
    end
  end

  // debug return, exception report
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      DEBUG_CLEAR_OUT  <= 1'b0;
      PC_LOAD_OUT      <= 1'b0;
      PC_OUT           <= 32'h0;
      ISA_MODE_BIT_OUT <= 1'b0;
      SQUASH_NEXT_OUT  <= 1'b0;
      EXC_VALID_OUT    <= 1'b0;
      EXC_CODE_OUT     <= DRX_EXC_NONE;
    end
    else
    begin
      DEBUG_CLEAR_OUT <= debug_exception_return_ok;                                         // see RQ1
      PC_LOAD_OUT     <= debug_exception_return_ok;
      SQUASH_NEXT_OUT <= debug_exception_return_ok;                                         // see RQ3
      EXC_VALID_OUT   <= exc_ri | exc_cpu;                                 // see RQ2
      EXC_CODE_OUT    <= next_exc;
      if (debug_exception_return_ok)
      begin
        PC_OUT           <= next_pc;
        ISA_MODE_BIT_OUT <= next_isa;
      end
    end
  end

  // effective interrupt enable is held low while the hazard is pending, then follows the registered status bit
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      ie_shadow <= 1'b0;
    else if (hazard_clear | ~hazard_pending)
      ie_shadow <= STATUS_IN[`DRX_IE_BIT];                                 // see RQ9
  end
  assign INTR_ENABLE_EFFECTIVE_OUT = ie_shadow & ~hazard_pending;

  // result registers take the newest divide's results
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      RESULT_HIGH_REGISTER_OUT <= 32'h0;
      RESULT_LOW_REGISTER_OUT  <= 32'h0;
    end
    else if (div_done & ~div_start)                                        // see RQ20
    begin
      RESULT_HIGH_REGISTER_OUT <= div_rem;                                 // see RQ11
      RESULT_LOW_REGISTER_OUT  <= div_quot;                                // see RQ15
    end
  end
endmodule : drx_decode_exec

/* drx_decode_exec_assertions.sv */
// assertion checker for the decode and execute block
`timescale 1ns/1ps
module drx_chk
(
  input wire logic              CLOCK_IN,
  input wire logic              RESETN_IN,
  input wire logic              ISSUE_VALID_IN,
  input wire logic [31:0]       INSTR_IN,
  input wire logic              READ_RESULT_LOW_IN,
  input wire logic              CP0_USABLE_IN,
  input wire logic              COMPAT_RELEASE1_IN,
  input wire logic              COMPRESSED_ISA_PRESENT_IN,
  input wire logic              DEBUG_MODE_FLAG_IN,
  input wire logic [31:0]       SAVED_DEBUG_PC_IN,
  input wire logic [31:0]       STATUS_IN,
  input wire logic              STALL_OUT,
  input wire logic              EXC_VALID_OUT,
  input wire drx_pkg::drx_exc_t EXC_CODE_OUT,
  input wire logic              STATUS_WE_OUT,
  input wire logic [31:0]       STATUS_OUT,
  input wire logic              REG_WE_OUT,
  input wire logic [31:0]       REG_DATA_OUT,
  input wire logic              DEBUG_CLEAR_OUT,
  input wire logic              PC_LOAD_OUT,
  input wire logic [31:0]       PC_OUT
);
  import drx_pkg::*;
  // decode of the taken instruction word
  wire ok  = ISSUE_VALID_IN && !STALL_OUT;
  wire grp = INSTR_IN[31:26] == 6'h00 && INSTR_IN[5:0] == 6'h3C;
  wire di  = ok && grp && INSTR_IN[25:21] == 5'h00 && INSTR_IN[15:6] == 10'h11D;
  wire dv  = ok && grp && (INSTR_IN[15:6] == 10'h2AC || INSTR_IN[15:6] == 10'h2EC);
  wire dr  = ok && grp && INSTR_IN[25:16] == 10'h000 && INSTR_IN[15:6] == 10'h38D;
  wire dio = di && CP0_USABLE_IN && !COMPAT_RELEASE1_IN;
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);
  // interrupt disable, divide, debug return and barrier relations
  a_di_status: assert property (dio |=> STATUS_WE_OUT && STATUS_OUT == ($past(STATUS_IN) & 32'hFFFFFFFE))
    else $error("status not cleared");
  a_di_old_value: assert property (dio && INSTR_IN[20:16] != 5'h00 |=> REG_WE_OUT && REG_DATA_OUT == $past(STATUS_IN))
    else $error("old status not written");
  a_di_no_cp0: assert property (di && !CP0_USABLE_IN && !COMPAT_RELEASE1_IN |=> EXC_VALID_OUT
    && EXC_CODE_OUT == DRX_EXC_CPU && !STATUS_WE_OUT && !REG_WE_OUT) else $error("no cp0 access not refused");
  a_di_reserved: assert property (di && CP0_USABLE_IN && COMPAT_RELEASE1_IN |=> EXC_VALID_OUT
    && EXC_CODE_OUT == DRX_EXC_RI && !STATUS_WE_OUT) else $error("compat option not reserved");
  a_div_no_trap: assert property (dv |=> !EXC_VALID_OUT)
    else $error("divide trapped");
  a_div_interlock: assert property (dv ##2 (ISSUE_VALID_IN && READ_RESULT_LOW_IN) |-> STALL_OUT)
    else $error("result read not stalled");
  a_dret_restore: assert property (dr && DEBUG_MODE_FLAG_IN && CP0_USABLE_IN && COMPRESSED_ISA_PRESENT_IN |=>
    DEBUG_CLEAR_OUT && PC_LOAD_OUT && PC_OUT == ($past(SAVED_DEBUG_PC_IN) & 32'hFFFFFFFE)) else $error("bad return");
  a_dret_not_debug: assert property (dr && !DEBUG_MODE_FLAG_IN && CP0_USABLE_IN |=> EXC_VALID_OUT
    && EXC_CODE_OUT == DRX_EXC_RI && !PC_LOAD_OUT) else $error("return outside debug");
  a_barrier_stall: assert property (ISSUE_VALID_IN && INSTR_IN == 32'h00001800 && $past(dio) |-> STALL_OUT)
    else $error("barrier not stalled");
  // main scenarios
  c_di: cover property (dio);
  c_div: cover property (dv);
  c_dret: cover property (dr && DEBUG_MODE_FLAG_IN);
endmodule : drx_chk

/* drx_cp0_model.sv */
// status register model standing beside the decoder
`timescale 1ns/1ps
module drx_cp0_model
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        load_in,
  input  wire logic [31:0] load_value_in,
  input  wire logic        we_in,
  input  wire logic [31:0] data_in,
  output logic [31:0]      status_out
);
  // preset by the bench, written back by interrupt disable
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      status_out <= 32'h00000000;
    else if (load_in)
      status_out <= load_value_in;
    else if (we_in)
      status_out <= data_in;
  end
endmodule : drx_cp0_model

/* drx_decode_exec_test.sv */
// self-checking bench for the decode and execute block
`timescale 1ns/1ps
module drx_decode_exec_test;
  import drx_pkg::*;
  logic CLOCK_IN = 1'b0, RESETN_IN = 1'b0, ISSUE_VALID_IN = 1'b0, IN_DELAY_SLOT_IN = 1'b0, load = 1'b0;
  logic READ_RESULT_HIGH_IN = 1'b0, READ_RESULT_LOW_IN = 1'b0, HAZARD_JUMP_IN = 1'b0, EXCEPTION_RETURN_IN = 1'b0;
  logic CP0_USABLE_IN = 1'b1, COMPAT_RELEASE1_IN = 1'b0, COMPRESSED_ISA_PRESENT_IN = 1'b0, DEBUG_MODE_FLAG_IN = 1'b0;
  logic [31:0] INSTR_IN = 32'h0, SOURCE_DATA_IN = 32'h0, TARGET_DATA_IN = 32'h0, SAVED_DEBUG_PC_IN = 32'h0;
  logic [31:0] load_value = 32'h0;
  wire logic [31:0] STATUS_IN, STATUS_OUT, REG_DATA_OUT, PC_OUT, RESULT_HIGH_REGISTER_OUT, RESULT_LOW_REGISTER_OUT;
  wire logic STALL_OUT, EXC_VALID_OUT, STATUS_WE_OUT, REG_WE_OUT, DEBUG_CLEAR_OUT, PC_LOAD_OUT, ISA_MODE_BIT_OUT;
  wire logic SQUASH_NEXT_OUT, INTR_ENABLE_EFFECTIVE_OUT;
  wire logic [4:0] REG_ADDR_OUT;
  drx_exc_t EXC_CODE_OUT;
  int n_fail = 0;
  int checks = 0;
  // clock, design and status model
  always #5 CLOCK_IN = ~CLOCK_IN;
  drx_decode_exec drx_decode_exec_inst (.CLOCK_IN, .RESETN_IN, .ISSUE_VALID_IN, .INSTR_IN, .IN_DELAY_SLOT_IN,
    .SOURCE_DATA_IN, .TARGET_DATA_IN, .READ_RESULT_HIGH_IN, .READ_RESULT_LOW_IN, .HAZARD_JUMP_IN, .EXCEPTION_RETURN_IN,
    .CP0_USABLE_IN, .COMPAT_RELEASE1_IN, .COMPRESSED_ISA_PRESENT_IN, .DEBUG_MODE_FLAG_IN, .SAVED_DEBUG_PC_IN,
    .STATUS_IN, .STALL_OUT, .EXC_VALID_OUT, .EXC_CODE_OUT, .STATUS_WE_OUT, .STATUS_OUT, .REG_WE_OUT, .REG_ADDR_OUT,
    .REG_DATA_OUT, .DEBUG_CLEAR_OUT, .PC_LOAD_OUT, .PC_OUT, .ISA_MODE_BIT_OUT, .SQUASH_NEXT_OUT,
    .INTR_ENABLE_EFFECTIVE_OUT, .RESULT_HIGH_REGISTER_OUT, .RESULT_LOW_REGISTER_OUT);
  drx_cp0_model drx_cp0_model_inst (.clk_in(CLOCK_IN), .resetn_in(RESETN_IN), .load_in(load),
    .load_value_in(load_value), .we_in(STATUS_WE_OUT), .data_in(STATUS_OUT), .status_out(STATUS_IN));
  // verdict and end of run
  task complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // value comparison
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // present one instruction until taken, return at the falling edge after the take
  task issue(input logic [31:0] word, output int waited);
    ISSUE_VALID_IN = 1'b1;
    INSTR_IN = word;
    waited = 0;
    #1;
    while (STALL_OUT !== 1'b0)
    begin
      if (waited == 60)
      begin
        n_fail++;
        complete_run();
      end
      @(negedge CLOCK_IN);
      #1;
      waited++;
    end
    @(negedge CLOCK_IN);
    ISSUE_VALID_IN = 1'b0;
  endtask : issue
  // interrupt disable to a named and to the zero register, then a barrier in a slot
  task t_intdis;
    int w;
    for (int k = 0; k < 2; k++)
    begin
      load = 1'b1;
      load_value = 32'h0000F401;
      @(negedge CLOCK_IN);
      load = 1'b0;
      issue({6'h00, 5'h00, (k == 0) ? 5'h05 : 5'h00, 10'h11D, 6'h3C}, w);
      cmp({STATUS_WE_OUT, REG_WE_OUT}, (k == 0) ? 2'h3 : 2'h2);
      cmp(STATUS_OUT, 32'h0000F400);
      if (k == 0) cmp({REG_ADDR_OUT, REG_DATA_OUT}, {5'h05, 32'h0000F401});
      IN_DELAY_SLOT_IN = 1'b1;
      issue(32'h00001800, w);
      cmp(w != 0, 1'b1);
      cmp(INTR_ENABLE_EFFECTIVE_OUT, 1'b0);
      IN_DELAY_SLOT_IN = 1'b0;
    end
  endtask : t_intdis
  // interrupt disable refused without access and under the compatibility option
  task t_intdis_refused;
    int w;
    for (int k = 0; k < 2; k++)
    begin
      CP0_USABLE_IN = (k == 1);
      COMPAT_RELEASE1_IN = (k == 1);
      issue({6'h00, 5'h00, 5'h05, 10'h11D, 6'h3C}, w);
      cmp({EXC_VALID_OUT, STATUS_WE_OUT, REG_WE_OUT}, 3'h4);
      cmp(EXC_CODE_OUT, (k == 1) ? DRX_EXC_RI : DRX_EXC_CPU);
    end
    COMPAT_RELEASE1_IN = 1'b0;
  endtask : t_intdis_refused
  // divides read back through the interlock; last row has a zero divisor, is not read back and is aborted by the next divide
  task t_divide;
    int w;
    logic [31:0] t [5][5] = '{'{32'h1, 32'hFFFFFFF9, 32'h2, 32'hFFFFFFFD, 32'hFFFFFFFF},
      '{32'h0, 32'hFFFFFFF9, 32'h2, 32'h7FFFFFFC, 32'h1}, '{32'h1, 32'h64, 32'h7, 32'hE, 32'h2},
      '{32'h1, 32'h64, 32'hFFFFFFF9, 32'hFFFFFFF2, 32'h2}, '{32'h0, 32'h5, 32'h0, 32'h0, 32'h0}};
    for (int k = 0; k < 6; k++)
    begin
      TARGET_DATA_IN = t[k % 5][1];
      SOURCE_DATA_IN = t[k % 5][2];
      issue({6'h00, 5'h02, 5'h03, t[k % 5][0][0] ? 10'h2AC : 10'h2EC, 6'h3C}, w);
      cmp(EXC_VALID_OUT, 1'b0);
      READ_RESULT_LOW_IN = (k != 4);
      READ_RESULT_HIGH_IN = (k == 4);
      if (k != 4) issue(32'h0, w);
      READ_RESULT_LOW_IN = 1'b0;
      READ_RESULT_HIGH_IN = 1'b0;
      if (k != 4) cmp(w > 20, 1'b1);
      if (k < 4 || k == 5) cmp(RESULT_LOW_REGISTER_OUT, t[k % 5][3]);
      if (k < 4 || k == 5) cmp(RESULT_HIGH_REGISTER_OUT, t[k % 5][4]);
    end
  endtask : t_divide
  // debug return with and without compressed code, then refused cases
  task t_dret;
    int w;
    SAVED_DEBUG_PC_IN = 32'h80001235;
    for (int k = 0; k < 4; k++)
    begin
      COMPRESSED_ISA_PRESENT_IN = (k == 1);
      DEBUG_MODE_FLAG_IN = (k != 2);
      CP0_USABLE_IN = (k != 3);
      issue({6'h00, 10'h000, 10'h38D, 6'h3C}, w);
      if (k < 2) cmp({DEBUG_CLEAR_OUT, PC_LOAD_OUT, SQUASH_NEXT_OUT, EXC_VALID_OUT}, 4'hE);
      if (k < 2) cmp(PC_OUT, (k == 1) ? 32'h80001234 : 32'h80001235);
      if (k == 1) cmp(ISA_MODE_BIT_OUT, 1'b1);
      if (k > 1) cmp({EXC_VALID_OUT, PC_LOAD_OUT, DEBUG_CLEAR_OUT}, 3'h4);
      if (k > 1) cmp(EXC_CODE_OUT, (k == 2) ? DRX_EXC_RI : DRX_EXC_CPU);
    end
  endtask : t_dret
  // reset, then the scenarios
  initial
  begin
    repeat (2) @(negedge CLOCK_IN);
    RESETN_IN = 1'b1;
    t_intdis();
    t_intdis_refused();
    t_divide();
    t_dret();
    complete_run();
  end
endmodule : drx_decode_exec_test
bind drx_decode_exec drx_chk drx_chk_inst (.CLOCK_IN, .RESETN_IN, .ISSUE_VALID_IN, .INSTR_IN, .READ_RESULT_LOW_IN,
  .CP0_USABLE_IN, .COMPAT_RELEASE1_IN, .COMPRESSED_ISA_PRESENT_IN, .DEBUG_MODE_FLAG_IN, .SAVED_DEBUG_PC_IN,
  .STATUS_IN, .STALL_OUT, .EXC_VALID_OUT, .EXC_CODE_OUT, .STATUS_WE_OUT, .STATUS_OUT, .REG_WE_OUT, .REG_DATA_OUT,
  .DEBUG_CLEAR_OUT, .PC_LOAD_OUT, .PC_OUT);
